/* File: pdw_defines.svh */
`ifndef PDW_DEFINES_SVH
`define PDW_DEFINES_SVH

// **********
// Register offsets
// **********
`define PDW_ADDR_SAFE_VALUES     16'h0021
`define PDW_ADDR_SERIAL_PERIOD   16'h0023
`define PDW_ADDR_FIELDBUS_PERIOD 16'h0024
`define PDW_ADDR_CHAIN_CFG       16'h0025
`define PDW_ADDR_CHAIN_CUR       16'h0026
`define PDW_ADDR_SCRIPT_EN       16'h0032
`define PDW_ADDR_SCRIPT_PORT     16'h0033

// **********
// Reset values and accepted ranges
// **********
`define PDW_RST_SAFE_VALUES      8'h00
`define PDW_RST_PERIOD           8'h00
`define PDW_RST_CHAIN_CFG        8'h03
`define PDW_RST_SCRIPT_EN        8'h00
`define PDW_RST_SCRIPT_PORT      8'h01
`define PDW_MAX_SAFE_VALUES      8'h3f
`define PDW_MAX_CHAIN_CFG        8'h07
`define PDW_MAX_SCRIPT_EN        8'h01
`define PDW_MAX_SCRIPT_PORT      8'h01
`define PDW_PERIOD_OFF           8'h00

// **********
// Field positions
// **********
`define PDW_SAFE_SERIAL_LSB      4
`define PDW_SAFE_FIELDBUS_LSB    2
`define PDW_SAFE_CHAIN_LSB       0
`define PDW_CHAIN_LED_BIT        0
`define PDW_CHAIN_IN_LSB         1
`define PDW_PORT_CONFIG_DEBUG    1'b0
`define PDW_PORT_SERIAL_DATA     1'b1

// **********
// Timing
// **********
`define PDW_TICK_MS              1
`define PDW_CLK_PERIOD_NS        4
`define PDW_TICK_CYCLES ((`PDW_TICK_MS * 1000000) / `PDW_CLK_PERIOD_NS)

`endif

/* File: pdw_pkg.sv */
package pdw_pkg;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {
    PDW_SAFE_ZERO = 2'b00,
    PDW_SAFE_ONE  = 2'b01,
    PDW_SAFE_HOLD = 2'b10
  } pdw_safe_mode_t;

  typedef enum logic [2:0] {
    PDW_SCR_IDLE = 3'b001,
    PDW_SCR_RUN  = 3'b010,
    PDW_SCR_HOLD = 3'b100
  } pdw_script_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] data;
  } pdw_reg_req_t;

  typedef struct packed {
    logic        done;
    logic        error;
    logic [15:0] rd_data;
  } pdw_reg_rsp_t;

  typedef struct packed {
    logic [7:0] safe_values;
    logic [7:0] serial_period;
    logic [7:0] fieldbus_period;
    logic [7:0] chain_cfg;
    logic [7:0] script_en;
    logic [7:0] script_port;
  } pdw_persist_t;

  typedef struct packed {
    logic       led_out0;
    logic [1:0] switch_in;
  } pdw_chain_use_t;

endpackage

/* File: pdw_validity_timer.sv */
`include "pdw_defines.svh"

module pdw_validity_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ms_tick,
  input  wire logic       produce,
  input  wire logic [7:0] period,
  output logic            invalid
);

  logic [7:0] elapsed_reg;
  logic       invalid_reg;
  logic       off;

  assign off     = (period == `PDW_PERIOD_OFF);
  assign invalid = invalid_reg;

  // **********
  // Millisecond counter
  // **********
  // The tick is free running, so the first tick after a production
  // may come early: a timeout lands between period-1 and period ms.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      elapsed_reg <= 8'h00;
    end else if (produce || off) begin
      elapsed_reg <= 8'h00; // [RQ14]
    end else if (ms_tick && (elapsed_reg != 8'hff)) begin
      elapsed_reg <= elapsed_reg + 8'h01; // [RQ14]
    end
  end

  // **********
  // Invalid flag
  // **********
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      invalid_reg <= 1'b0;
    end else if (off) begin
      invalid_reg <= 1'b0; // [RQ2]
    end else if (produce) begin
      invalid_reg <= 1'b0; // [RQ14]
    end else if (ms_tick && (elapsed_reg >= (period - 8'h01))) begin
      invalid_reg <= 1'b1; // [RQ1] [RQ3]
    end
  end

endmodule

/* File: pdw_config_regs.sv */
`include "pdw_defines.svh"

// Summary of operation
// [RQ1] A nonzero validity value is the timeout in ms for the next production.
// [RQ2] A validity value of zero disables the timeout; data stays valid.
// [RQ3] A missed production marks that interface's input data invalid.
// [RQ4] Consumers of an invalid input area switch to their chosen safe values.
// [RQ5] Serial and fieldbus ports have separate byte-wide persistent periods.
// [RQ6] Chain bit 0 set reserves output shift register 0 for status LEDs.
// [RQ7] Chain bits 2:1 reserve none, input register 0, or inputs 0 and 1.
// [RQ8] Chain configuration resets to 0x03, accepts 0x00 to 0x07, persists.
// [RQ9] An assignment register reports the chain usage currently in effect.
// [RQ10] Script enable 0 stops and 1 starts the script; resets to 0, persists.
// [RQ11] A port-select register chooses the script's serial interface.
// [RQ12] Safe value codes: 00 zeros, 01 ones, 10 hold last data.
// [RQ13] A script on the debug port blocks the menu until off and restarted.
// [RQ14] Timers count ms ticks, restart on production, fresh data clears invalid.
// [RQ15] Reserved bits or out-of-range values leave registers unchanged.
module pdw_config_regs
  import pdw_pkg::*;
#(
  parameter int TICK_CYCLES = `PDW_TICK_CYCLES,
  parameter int DATA_W      = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire pdw_reg_req_t      reg_req,
  output pdw_reg_rsp_t           reg_rsp,
  input  wire logic [DATA_W-1:0] serial_in_data,
  input  wire logic              serial_produce,
  input  wire logic [DATA_W-1:0] fieldbus_in_data,
  input  wire logic              fieldbus_produce,
  output logic      [DATA_W-1:0] serial_out_data,
  output logic      [DATA_W-1:0] fieldbus_out_data,
  output logic                   serial_data_invalid,
  output logic                   fieldbus_data_invalid,
  output pdw_chain_use_t         chain_use,
  input  wire logic              module_restart,
  input  wire logic              persist_load,
  input  wire pdw_persist_t      persist_in,
  output pdw_persist_t           persist_out,
  output logic                   persist_save,
  output logic                   script_active,
  output logic                   script_port,
  output logic                   cfg_menu_enable
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NIF = 2;

  // **********
  // Functions
  // **********
  function automatic logic pdw_is_mapped(input logic [15:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      `PDW_ADDR_SAFE_VALUES,
      `PDW_ADDR_SERIAL_PERIOD,
      `PDW_ADDR_FIELDBUS_PERIOD,
      `PDW_ADDR_CHAIN_CFG,
      `PDW_ADDR_CHAIN_CUR,
      `PDW_ADDR_SCRIPT_EN,
      `PDW_ADDR_SCRIPT_PORT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Code 11 has no meaning, so a value carrying it is refused whole.
  function automatic logic pdw_safe_ok(input logic [7:0] v);
    logic ok;
    ok = (v <= `PDW_MAX_SAFE_VALUES);
    ok = ok && (v[`PDW_SAFE_SERIAL_LSB +: 2] != 2'b11);
    ok = ok && (v[`PDW_SAFE_FIELDBUS_LSB +: 2] != 2'b11);
    ok = ok && (v[`PDW_SAFE_CHAIN_LSB +: 2] != 2'b11);
    return ok;
  endfunction

  function automatic logic [DATA_W-1:0] pdw_safe_word(
    input logic [1:0]        mode,
    input logic [DATA_W-1:0] last
  );
    logic [DATA_W-1:0] w;
    w = last;
    if (mode == PDW_SAFE_ZERO) begin
      w = '0; // [RQ12]
    end else if (mode == PDW_SAFE_ONE) begin
      w = '1; // [RQ12]
    end
    return w;
  endfunction

  // **********
  // Registers
  // **********
  logic [7:0]        safe_values_reg;
  logic [7:0]        serial_period_reg;
  logic [7:0]        fieldbus_period_reg;
  logic [7:0]        chain_cfg_reg;
  logic [7:0]        chain_cur_reg;
  logic [7:0]        script_en_reg;
  logic [7:0]        script_port_reg;
  pdw_script_state_t script_state_reg;
  pdw_script_state_t script_state_next;
  logic              script_port_eff_reg;
  pdw_reg_rsp_t      reg_rsp_reg;
  logic              persist_save_reg;
  logic [TW-1:0]     tick_cnt_reg;
  logic              ms_tick_reg;

  logic [DATA_W-1:0] out_data_reg [NIF];
  logic [DATA_W-1:0] in_data      [NIF];
  logic              produce      [NIF];
  logic [7:0]        period       [NIF];
  logic [1:0]        safe_mode    [NIF];
  logic              data_invalid [NIF];

  logic              wr_ok;
  logic              wr_store;
  logic [15:0]       rd_word;
  logic [7:0]        wr_byte;

  assign wr_byte = reg_req.data[7:0];

  // **********
  // Millisecond time base
  // **********
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      ms_tick_reg  <= 1'b1; // [RQ14]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
      ms_tick_reg  <= 1'b0;
    end
  end

  // **********
  // Write decode
  // **********
  // The access path is byte wide, so a set upper byte is refused.
  always_comb begin
    wr_ok = 1'b0;
    if (reg_req.data[15:8] == 8'h00) begin
      unique case (reg_req.addr)
        `PDW_ADDR_SAFE_VALUES:     wr_ok = pdw_safe_ok(wr_byte); // [RQ15]
        `PDW_ADDR_SERIAL_PERIOD:   wr_ok = 1'b1;
        `PDW_ADDR_FIELDBUS_PERIOD: wr_ok = 1'b1;
        `PDW_ADDR_CHAIN_CFG:       wr_ok = (wr_byte <= `PDW_MAX_CHAIN_CFG); // [RQ8]
        `PDW_ADDR_CHAIN_CUR:       wr_ok = 1'b1;
        `PDW_ADDR_SCRIPT_EN:       wr_ok = (wr_byte <= `PDW_MAX_SCRIPT_EN); // [RQ15]
        `PDW_ADDR_SCRIPT_PORT:     wr_ok = (wr_byte <= `PDW_MAX_SCRIPT_PORT); // [RQ15]
        default:                   wr_ok = 1'b0;
      endcase
    end
  end

  assign wr_store = reg_req.wr && wr_ok && !persist_load;

  // **********
  // Configuration storage
  // **********
  // A restore from persistent storage wins over a host write in the
  // same cycle, since it only happens while the module starts up.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      safe_values_reg     <= `PDW_RST_SAFE_VALUES;
      serial_period_reg   <= `PDW_RST_PERIOD; // [RQ5]
      fieldbus_period_reg <= `PDW_RST_PERIOD; // [RQ5]
      chain_cfg_reg       <= `PDW_RST_CHAIN_CFG; // [RQ8]
      script_en_reg       <= `PDW_RST_SCRIPT_EN; // [RQ10]
      script_port_reg     <= `PDW_RST_SCRIPT_PORT;
    end else if (persist_load) begin
      safe_values_reg     <= persist_in.safe_values;
      serial_period_reg   <= persist_in.serial_period; // [RQ5]
      fieldbus_period_reg <= persist_in.fieldbus_period; // [RQ5]
      chain_cfg_reg       <= persist_in.chain_cfg; // [RQ8]
      script_en_reg       <= persist_in.script_en; // [RQ10]
      script_port_reg     <= persist_in.script_port;
    end else if (wr_store) begin
      unique case (reg_req.addr)
        `PDW_ADDR_SAFE_VALUES:     safe_values_reg     <= wr_byte;
        `PDW_ADDR_SERIAL_PERIOD:   serial_period_reg   <= wr_byte; // [RQ5]
        `PDW_ADDR_FIELDBUS_PERIOD: fieldbus_period_reg <= wr_byte; // [RQ5]
        `PDW_ADDR_CHAIN_CFG:       chain_cfg_reg       <= wr_byte; // [RQ8]
        `PDW_ADDR_SCRIPT_EN:       script_en_reg       <= wr_byte; // [RQ10]
        `PDW_ADDR_SCRIPT_PORT:     script_port_reg     <= wr_byte; // [RQ11]
        default: ;
      endcase
    end
  end

  // **********
  // Shift chain assignment in effect
  // **********
  // The chain is only re-laid out on a restart or a persistent load, so a new configuration
  // shows here once the module has been restarted.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chain_cur_reg <= `PDW_RST_CHAIN_CFG;
    end else if (persist_load) begin
      chain_cur_reg <= persist_in.chain_cfg; // [RQ9]
    end else if (module_restart) begin
      chain_cur_reg <= chain_cfg_reg; // [RQ9]
    end
  end

  always_comb begin
    chain_use.led_out0 = chain_cur_reg[`PDW_CHAIN_LED_BIT]; // [RQ6]
    chain_use.switch_in = 2'b00; // [RQ7]
    unique case (chain_cur_reg[`PDW_CHAIN_IN_LSB +: 2])
      2'b00:   chain_use.switch_in = 2'b00; // [RQ7]
      2'b01:   chain_use.switch_in = 2'b01; // [RQ7]
      2'b10:   chain_use.switch_in = 2'b11; // [RQ7]
      default: chain_use.switch_in = 2'b11;
    endcase
  end

  // **********
  // Script control
  // **********
  always_comb begin
    script_state_next = script_state_reg;
    unique case (script_state_reg)
      PDW_SCR_IDLE: begin
        if (script_en_reg == `PDW_MAX_SCRIPT_EN) begin
          script_state_next = PDW_SCR_RUN; // [RQ10]
        end
      end
      PDW_SCR_RUN: begin
        if (script_en_reg == `PDW_RST_SCRIPT_EN) begin
          if (script_port_eff_reg == `PDW_PORT_CONFIG_DEBUG) begin
            script_state_next = PDW_SCR_HOLD; // [RQ13]
          end else begin
            script_state_next = PDW_SCR_IDLE; // [RQ10]
          end
        end
      end
      PDW_SCR_HOLD: begin
        if (module_restart) begin
          script_state_next = PDW_SCR_IDLE; // [RQ13]
        end
      end
      default: script_state_next = PDW_SCR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      script_state_reg <= PDW_SCR_IDLE;
    end else begin
      script_state_reg <= script_state_next;
    end
  end

  // The port is caught when the script starts, so a later change only
  // takes effect on the next start.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      script_port_eff_reg <= `PDW_PORT_SERIAL_DATA;
    end else if ((script_state_reg == PDW_SCR_IDLE) &&
                 (script_state_next == PDW_SCR_RUN)) begin
      script_port_eff_reg <= script_port_reg[0]; // [RQ11]
    end
  end

  assign script_active   = (script_state_reg != PDW_SCR_IDLE); // [RQ10]
  assign script_port     = script_port_eff_reg; // [RQ11]
  assign cfg_menu_enable = !(script_active &&
    (script_port_eff_reg == `PDW_PORT_CONFIG_DEBUG)); // [RQ13]

  // **********
  // Validity watch and safe values
  // **********
  assign in_data[0]   = serial_in_data;
  assign in_data[1]   = fieldbus_in_data;
  assign produce[0]   = serial_produce;
  assign produce[1]   = fieldbus_produce;
  assign period[0]    = serial_period_reg;
  assign period[1]    = fieldbus_period_reg;
  assign safe_mode[0] = safe_values_reg[`PDW_SAFE_SERIAL_LSB +: 2];
  assign safe_mode[1] = safe_values_reg[`PDW_SAFE_FIELDBUS_LSB +: 2];

  genvar gi;
  generate
    for (gi = 0; gi < NIF; gi++) begin : g_if
      pdw_validity_timer u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ms_tick (ms_tick_reg),
        .produce (produce[gi]),
        .period  (period[gi]),
        .invalid (data_invalid[gi])
      );

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          out_data_reg[gi] <= '0;
        end else if (produce[gi]) begin
          out_data_reg[gi] <= in_data[gi];
        end else if (data_invalid[gi]) begin
          out_data_reg[gi] <= pdw_safe_word(safe_mode[gi],
                                            out_data_reg[gi]); // [RQ4]
        end
      end
    end
  endgenerate

  assign serial_out_data       = out_data_reg[0];
  assign fieldbus_out_data     = out_data_reg[1];
  assign serial_data_invalid   = data_invalid[0]; // [RQ3]
  assign fieldbus_data_invalid = data_invalid[1]; // [RQ3]

  // **********
  // Read path and response
  // **********
  always_comb begin
    rd_word = 16'h0000;
    unique case (reg_req.addr)
      `PDW_ADDR_SAFE_VALUES:     rd_word = {8'h00, safe_values_reg};
      `PDW_ADDR_SERIAL_PERIOD:   rd_word = {8'h00, serial_period_reg};
      `PDW_ADDR_FIELDBUS_PERIOD: rd_word = {8'h00, fieldbus_period_reg};
      `PDW_ADDR_CHAIN_CFG:       rd_word = {8'h00, chain_cfg_reg};
      `PDW_ADDR_CHAIN_CUR:       rd_word = {8'h00, chain_cur_reg}; // [RQ9]
      `PDW_ADDR_SCRIPT_EN:       rd_word = {8'h00, script_en_reg};
      `PDW_ADDR_SCRIPT_PORT:     rd_word = {8'h00, script_port_reg};
      default:                   rd_word = 16'h0000;
    endcase
  end

  // A write takes precedence when both strobes are high.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rsp_reg <= '0;
    end else if (reg_req.wr) begin
      reg_rsp_reg.done    <= 1'b1;
      reg_rsp_reg.error   <= !wr_ok || persist_load; // [RQ15]
      reg_rsp_reg.rd_data <= 16'h0000;
    end else if (reg_req.rd) begin
      reg_rsp_reg.done    <= 1'b1;
      reg_rsp_reg.error   <= !pdw_is_mapped(reg_req.addr);
      reg_rsp_reg.rd_data <= rd_word;
    end else begin
      reg_rsp_reg <= '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      persist_save_reg <= 1'b0;
    end else begin
      persist_save_reg <= wr_store &&
        (reg_req.addr != `PDW_ADDR_CHAIN_CUR); // [RQ5] [RQ8] [RQ10]
    end
  end

  assign reg_rsp      = reg_rsp_reg;
  assign persist_save = persist_save_reg;

  assign persist_out.safe_values     = safe_values_reg;
  assign persist_out.serial_period   = serial_period_reg;
  assign persist_out.fieldbus_period = fieldbus_period_reg;
  assign persist_out.chain_cfg       = chain_cfg_reg;
  assign persist_out.script_en       = script_en_reg;
  assign persist_out.script_port     = script_port_reg;

endmodule

/* File: pdw_host_model.sv */
module pdw_host_model
  import pdw_pkg::*;
(
  input  wire logic         ref_clk,
  output pdw_reg_req_t      reg_req,
  input  wire pdw_reg_rsp_t reg_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req = '0;

  // ******************************************************************
  // Register access
  // ******************************************************************
  // The bus is scrambled between requests, so a stale word never helps.
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output pdw_reg_rsp_t r);
    int n;
    @(posedge ref_clk);
    reg_req <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    r = '0;
    for (n = 0; n < 4 && r.done !== 1'b1; n++) begin
      #1 r = reg_rsp;
      if (r.done !== 1'b1) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: pdw_config_regs_properties.sv */
module pdw_checker
  import pdw_pkg::*;
#(
  parameter int TICK_CYCLES = 10,
  parameter int DATA_W      = 16
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire pdw_reg_req_t      reg_req,
  input wire pdw_reg_rsp_t      reg_rsp,
  input wire logic [DATA_W-1:0] serial_in_data,
  input wire logic              serial_produce,
  input wire logic [DATA_W-1:0] serial_out_data,
  input wire logic              serial_data_invalid,
  input wire logic              fieldbus_produce,
  input wire logic [DATA_W-1:0] fieldbus_out_data,
  input wire logic              fieldbus_data_invalid,
  input wire pdw_chain_use_t    chain_use,
  input wire logic              persist_load,
  input wire pdw_persist_t      persist_in,
  input wire pdw_persist_t      persist_out,
  input wire logic              persist_save,
  input wire logic              script_active,
  input wire logic              script_port,
  input wire logic              cfg_menu_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ******************************************************************
  // Properties
  // ******************************************************************
  req_answered_a: assert property (reg_req.wr || reg_req.rd |=> reg_rsp.done)
    else $error("request not answered");
  idle_quiet_a: assert property (!(reg_req.wr || reg_req.rd) |=>
    !reg_rsp.done && reg_rsp.rd_data == 16'h0000)
    else $error("answer without request");
  chain_refused_a: assert property (reg_req.wr && !persist_load &&
    reg_req.addr == 16'h0025 && reg_req.data > 16'h0007 |=>
    reg_rsp.error && $stable(persist_out.chain_cfg))
    else $error("chain value out of range taken");
  period_off_a: assert property (persist_out.serial_period == 8'h00 |=>
    !serial_data_invalid)
    else $error("invalid with timeout off");
  produce_clear_a: assert property (fieldbus_produce |=>
    !fieldbus_data_invalid)
    else $error("production did not clear invalid");
  produce_copy_a: assert property (serial_produce |=>
    serial_out_data == $past(serial_in_data))
    else $error("produced word not passed on");
  safe_ones_a: assert property (serial_data_invalid && !serial_produce &&
    persist_out.safe_values[5:4] == 2'b01 |=> &serial_out_data)
    else $error("ones not forced");
  hold_last_a: assert property (fieldbus_data_invalid && !fieldbus_produce &&
    persist_out.safe_values[3:2] == 2'b10 |=> $stable(fieldbus_out_data))
    else $error("held word changed");
  load_chain_a: assert property (persist_load &&
    persist_in.chain_cfg == 8'h05 |=> chain_use == 3'b111)
    else $error("chain use not applied");
  menu_block_a: assert property (script_active && !script_port |->
    !cfg_menu_enable)
    else $error("menu open under script");
  save_cause_a: assert property (persist_save |->
    reg_rsp.done && !reg_rsp.error)
    else $error("save without accepted write");

  cover property ($rose(serial_data_invalid));
  cover property (reg_rsp.done && reg_rsp.error);
  cover property ($rose(script_active) && !script_port);
endmodule

/* File: tb_top.sv */
module tb_top
  import pdw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic        e;
    logic [15:0] x;
  } pdw_tb_row_t;

  localparam pdw_tb_row_t ROWS [12] = '{
    '{16'h0023, 16'h0005, 1'b0, 16'h0005}, '{16'h0023, 16'h0105, 1'b1, 16'h0005},
    '{16'h0024, 16'h00ff, 1'b0, 16'h00ff}, '{16'h0025, 16'h0007, 1'b0, 16'h0007},
    '{16'h0025, 16'h0008, 1'b1, 16'h0007}, '{16'h0021, 16'h0026, 1'b0, 16'h0026},
    '{16'h0021, 16'h000c, 1'b1, 16'h0026}, '{16'h0032, 16'h0002, 1'b1, 16'h0000},
    '{16'h0033, 16'h0000, 1'b0, 16'h0000}, '{16'h0033, 16'h0002, 1'b1, 16'h0000},
    '{16'h0026, 16'h0005, 1'b0, 16'h0003}, '{16'h0030, 16'h0001, 1'b1, 16'h0000}};
  localparam logic [15:0] RA [7] = '{16'h0021, 16'h0023, 16'h0024, 16'h0025,
                                     16'h0026, 16'h0032, 16'h0033};
  localparam logic [15:0] RV [7] = '{16'h0, 16'h0, 16'h0, 16'h3, 16'h3, 16'h0,
                                     16'h1};

  logic           ref_clk = 1'b0;
  logic           rst = 1'b1;
  pdw_reg_req_t   reg_req;
  pdw_reg_rsp_t   reg_rsp;
  logic [15:0]    serial_in_data = '0;
  logic [15:0]    fieldbus_in_data = '0;
  logic           serial_produce = 1'b0;
  logic           fieldbus_produce = 1'b0;
  logic [15:0]    serial_out_data;
  logic [15:0]    fieldbus_out_data;
  logic           serial_data_invalid;
  logic           fieldbus_data_invalid;
  pdw_chain_use_t chain_use;
  logic           module_restart = 1'b0;
  logic           persist_load = 1'b0;
  pdw_persist_t   persist_in = '0;
  pdw_persist_t   persist_out;
  logic           persist_save;
  logic           script_active;
  logic           script_port;
  logic           cfg_menu_enable;
  int             err_total = 0;
  int             n_compared = 0;
  int             k;

  always #2 ref_clk = ~ref_clk;

  pdw_host_model host (.ref_clk, .reg_req, .reg_rsp);
  pdw_config_regs #(.TICK_CYCLES(10)) dut (.ref_clk, .rst, .reg_req,
    .reg_rsp, .serial_in_data, .serial_produce, .fieldbus_in_data,
    .fieldbus_produce, .serial_out_data, .fieldbus_out_data,
    .serial_data_invalid, .fieldbus_data_invalid, .chain_use,
    .module_restart, .persist_load, .persist_in, .persist_out,
    .persist_save, .script_active, .script_port, .cfg_menu_enable);

  // **********
  // Helpers
  // **********
  task automatic chk(input string what, input logic [47:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] a, d, input logic e,
                     input logic [15:0] x);
    pdw_reg_rsp_t r;
    host.xfer(w, a, d, r);
    chk("error flag", e, r.error);
    if (!w) chk("read data", x, r.rd_data);
  endtask

  task automatic produce(input logic [15:0] s, f);
    @(posedge ref_clk);
    serial_in_data <= s;
    fieldbus_in_data <= f;
    serial_produce <= 1'b1;
    fieldbus_produce <= 1'b1;
    @(posedge ref_clk);
    serial_produce <= 1'b0;
    fieldbus_produce <= 1'b0;
    serial_in_data <= ~s;
    fieldbus_in_data <= ~f;
    #1;
  endtask

  // A restart and a load both act on one sampled edge only.
  task automatic pulse(input logic load);
    @(posedge ref_clk);
    if (load) persist_load <= 1'b1;
    else module_restart <= 1'b1;
    @(posedge ref_clk);
    persist_load <= 1'b0;
    module_restart <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [15:0] safe(input int c, input logic [15:0] v);
    return (c == 0) ? 16'h0000 : (c == 1) ? 16'hffff : v;
  endfunction

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // **********
  // Tests
  // **********
  initial begin
    #50000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      acc(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].e, 16'h0);
      acc(1'b0, ROWS[i].a, 16'h0, ROWS[i].a == 16'h0030, ROWS[i].x);
    end
    $display("test register table done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("stored reset", 48'h000000030001, persist_out);
    chk("reset flags", 7'b1010110, {chain_use, script_active, script_port,
        cfg_menu_enable, persist_save});
    @(posedge ref_clk);
    rst <= 1'b0;
    foreach (RA[i]) acc(1'b0, RA[i], 16'h0, 1'b0, RV[i]);
    $display("test reset done");
    acc(1'b1, 16'h0023, 16'h0002, 1'b0, 16'h0);
    acc(1'b1, 16'h0024, 16'h0003, 1'b0, 16'h0);
    for (int c = 0; c < 3; c++) begin
      acc(1'b1, 16'h0021, 16'(c * 20), 1'b0, 16'h0);
      produce(16'h5a5a, 16'hc3c3);
      for (k = 0; k < 30 && serial_data_invalid !== 1'b1; k++)
        @(posedge ref_clk) #1;
      chk("timeout window", 1'b1, k >= 11 && k <= 20);
      chk("fieldbus valid", 1'b0, fieldbus_data_invalid);
      @(posedge ref_clk) #1;
      chk("serial safe", safe(c, 16'h5a5a), serial_out_data);
      repeat (20) @(posedge ref_clk);
      #1 chk("fieldbus safe", {1'b1, safe(c, 16'hc3c3)},
        {fieldbus_data_invalid, fieldbus_out_data});
      produce(16'ha5a5, 16'h3c3c);
      chk("fresh data", {2'b00, 32'ha5a53c3c}, {serial_data_invalid,
        fieldbus_data_invalid, serial_out_data, fieldbus_out_data});
    end
    acc(1'b1, 16'h0023, 16'h0000, 1'b0, 16'h0);
    produce(16'h1234, 16'h4321);
    repeat (40) @(posedge ref_clk);
    #1 chk("timeout off", 1'b0, serial_data_invalid);
    $display("test validity done");
    acc(1'b1, 16'h0033, 16'h0000, 1'b0, 16'h0);
    acc(1'b1, 16'h0032, 16'h0001, 1'b0, 16'h0);
    @(posedge ref_clk) #1;
    chk("debug script", 3'b100, {script_active, script_port,
        cfg_menu_enable});
    acc(1'b1, 16'h0032, 16'h0000, 1'b0, 16'h0);
    repeat (2) @(posedge ref_clk);
    #1 chk("held until restart", 1'b1, script_active);
    pulse(1'b0);
    chk("after restart", 2'b01, {script_active, cfg_menu_enable});
    acc(1'b1, 16'h0033, 16'h0001, 1'b0, 16'h0);
    acc(1'b1, 16'h0032, 16'h0001, 1'b0, 16'h0);
    @(posedge ref_clk) #1;
    chk("serial script", 3'b111, {script_active, script_port,
        cfg_menu_enable});
    acc(1'b1, 16'h0032, 16'h0000, 1'b0, 16'h0);
    repeat (2) @(posedge ref_clk);
    #1 chk("script stopped", 1'b0, script_active);
    $display("test script done");
    acc(1'b1, 16'h0025, 16'h0002, 1'b0, 16'h0);
    pulse(1'b0);
    chk("chain use", 3'b001, chain_use);
    acc(1'b0, 16'h0026, 16'h0, 1'b0, 16'h0002);
    persist_in <= 48'h080102050001;
    pulse(1'b1);
    chk("loaded", 51'h7080102050001, {chain_use, persist_out});
    $display("test chain done");
    print_verdict();
  end
endmodule

bind pdw_config_regs pdw_checker #(.TICK_CYCLES(TICK_CYCLES),
  .DATA_W(DATA_W)) chk_i (.ref_clk, .rst, .reg_req, .reg_rsp,
  .serial_in_data, .serial_produce, .serial_out_data, .serial_data_invalid,
  .fieldbus_produce, .fieldbus_out_data, .fieldbus_data_invalid, .chain_use,
  .persist_load, .persist_in, .persist_out, .persist_save, .script_active,
  .script_port, .cfg_menu_enable);
